//--- hdl/deserializer_lock_output_ctrl.sv
`timescale 1ns/100ps

module deserializer_lock_output_ctrl #(
    parameter logic [4:0] RANDOM_WORDS = deser_pkg::RANDOM_LOCK_WORDS,
    parameter logic [4:0] SYNC_WORDS   = deser_pkg::SYNC_LOCK_WORDS,
    parameter logic [2:0] LOSS_WORDS   = deser_pkg::LOSS_LIMIT
) (
    input  wire logic        hclk,
    input  wire logic        hresetn,
    input  wire logic        hsel,
    input  wire logic [31:0] haddr,
    input  wire logic [1:0]  htrans,
    input  wire logic        hwrite,
    input  wire logic [2:0]  hsize,
    input  wire logic [31:0] hwdata,
    input  wire logic        hready,
    output logic             hreadyout,
    output logic             hresp,
    output logic [31:0]      hrdata,
    output logic             irq,
    input  wire logic        link_clock,
    input  wire logic        serial_in_pos,
    input  wire logic        serial_in_neg,
    input  wire logic        sleep_n,
    input  wire logic        out_enable,
    input  wire logic        strobe_rising,
    output logic [9:0]       data_out,
    output logic             data_oe,
    output logic             rclk_out,
    output logic             rclk_oe,
    output logic             lock_n_out,
    output logic             lock_n_oe
);

    ////////////////////////////////////////////////////////////////////////
    // Pin synchronisers.

    logic [2:0] link_s;
    logic [2:0] ctl_s;

    sync_two #(
        .WIDTH (3)
    ) u_link_sync (
        .clk   (hclk),
        .rst_n (hresetn),
        .d     ({link_clock, serial_in_pos, serial_in_neg}),
        .q     (link_s)
    );

    sync_two #(
        .WIDTH (3)
    ) u_ctl_sync (
        .clk   (hclk),
        .rst_n (hresetn),
        .d     ({sleep_n, out_enable, strobe_rising}),
        .q     (ctl_s)
    );

    logic awake;
    logic oe_en;
    logic rise_sel;

    assign awake    = ctl_s[2];
    assign oe_en    = ctl_s[1];
    assign rise_sel = ctl_s[0];

    ////////////////////////////////////////////////////////////////////////
    // Bit sampling on the link clock's rising edge.

    logic        lclk_prev_q;
    logic        bit_stb;
    logic        bit_done_q;
    logic [11:0] sh_q;
    logic [11:0] bad_sh_q;

    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            lclk_prev_q <= 1'b0;
        end else begin
            lclk_prev_q <= link_s[2];
        end
    end

    assign bit_stb = link_s[2] & ~lclk_prev_q;

    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            bit_done_q <= 1'b0;
        end else begin
            bit_done_q <= bit_stb & awake;
        end
    end

    // Equal levels on both legs mean no valid differential bit.
    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            sh_q     <= '0;
            bad_sh_q <= '0;
        end else if (!awake) begin
            sh_q     <= '0;
            bad_sh_q <= '0;
        end else if (bit_stb) begin
            sh_q     <= {sh_q[10:0], link_s[1]};
            bad_sh_q <= {bad_sh_q[10:0], link_s[1] == link_s[0]};
        end
    end

    // Activity detector: link clock edges must keep coming.
    logic [6:0] idle_cnt_q;
    logic       active_q;

    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            idle_cnt_q <= '0;
            active_q   <= 1'b0;
        end else if (!awake) begin
            idle_cnt_q <= '0;
            active_q   <= 1'b0;
        end else if (bit_stb) begin
            idle_cnt_q <= '0;
            active_q   <= 1'b1;
        end else if (idle_cnt_q == 7'(deser_pkg::IDLE_CYCLES - 1)) begin
            active_q   <= 1'b0;
        end else begin
            idle_cnt_q <= idle_cnt_q + 7'h01;
        end
    end

    ////////////////////////////////////////////////////////////////////////
    // Word framing and lock tracking.

    logic [9:0] word;
    logic       frame_ok;
    logic       is_sync;

    always_comb begin
        for (int i = 0; i < deser_pkg::DATA_BITS; i++) begin
            word[i] = sh_q[10-i];
        end
    end

    // Start clock bit high, stop clock bit low, no dead bit in the word.
    assign frame_ok = sh_q[11] & ~sh_q[0] & ~|bad_sh_q;
    assign is_sync  = word == deser_pkg::SYNC_WORD;

    deser_pkg::lock_state_t st_q;
    deser_pkg::lock_state_t st_d;
    logic [3:0]             bit_cnt_q;
    logic [3:0]             bit_cnt_d;
    logic [4:0]             good_q;
    logic [4:0]             good_d;
    logic [4:0]             good_inc;
    logic [2:0]             bad_q;
    logic [2:0]             bad_d;
    logic                   word_end;
    logic                   random_en_q;
    logic                   relock_q;

    assign word_end = bit_done_q & (bit_cnt_q == deser_pkg::LAST_BIT);
    assign good_inc = (good_q == 5'h1f) ? good_q : good_q + 5'h01;

    always_comb begin
        st_d      = st_q;
        good_d    = good_q;
        bad_d     = bad_q;
        bit_cnt_d = bit_cnt_q;
        if (bit_done_q) begin
            bit_cnt_d = word_end ? 4'h0 : bit_cnt_q + 4'h1;
            unique case (st_q)
                deser_pkg::LK_SEARCH: begin
                    // Slide one bit at a time until a frame fits.
                    if (frame_ok) begin
                        st_d      = deser_pkg::LK_CONFIRM;
                        bit_cnt_d = 4'h0;
                        good_d    = 5'h01;
                    end
                end
                deser_pkg::LK_CONFIRM: begin
                    if (word_end) begin
                        if (!frame_ok) begin
                            st_d   = deser_pkg::LK_SEARCH;
                            good_d = 5'h00;
                        end else if (is_sync && good_inc >= SYNC_WORDS) begin
                            st_d = deser_pkg::LK_LOCKED;
                        end else if (random_en_q && good_inc >= RANDOM_WORDS) begin
                            st_d = deser_pkg::LK_LOCKED;
                        end else begin
                            good_d = good_inc;
                        end
                        bad_d = 3'h0;
                    end
                end
                deser_pkg::LK_LOCKED: begin
                    if (word_end) begin
                        if (frame_ok) begin
                            bad_d = 3'h0;
                        end else if (bad_q + 3'h1 == LOSS_WORDS) begin
                            st_d   = deser_pkg::LK_SEARCH;
                            good_d = 5'h00;
                            bad_d  = 3'h0;
                        end else begin
                            bad_d = bad_q + 3'h1;
                        end
                    end
                end
                default: begin
                    st_d = deser_pkg::LK_SEARCH;
                end
            endcase
        end
        // Sleep, silence or a software request restart the search.
        if (!awake || !active_q || relock_q) begin
            st_d      = deser_pkg::LK_SEARCH;
            good_d    = 5'h00;
            bad_d     = 3'h0;
            bit_cnt_d = 4'h0;
        end
    end

    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            st_q      <= deser_pkg::LK_SEARCH;
            good_q    <= '0;
            bad_q     <= '0;
            bit_cnt_q <= '0;
        end else begin
            st_q      <= st_d;
            good_q    <= good_d;
            bad_q     <= bad_d;
            bit_cnt_q <= bit_cnt_d;
        end
    end

    logic locked;
    logic ev_acq;
    logic ev_lost;
    logic ev_word;

    assign locked  = st_q == deser_pkg::LK_LOCKED;
    assign ev_acq  = !locked && st_d == deser_pkg::LK_LOCKED;
    assign ev_lost = locked && st_d != deser_pkg::LK_LOCKED;
    assign ev_word = locked && word_end;

    ////////////////////////////////////////////////////////////////////////
    // Parallel data and recovered clock.

    logic [9:0] data_q;
    logic       rclk_q;

    // Words that led up to a loss still go out; they may be wrong.
    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            data_q <= '0;
        end else if (!awake) begin
            data_q <= '0;
        end else if (ev_word) begin
            data_q <= word;
        end
    end

    // Data change on the unselected edge, so the chosen edge sits mid-word.
    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            rclk_q <= 1'b0;
        end else if (!locked) begin
            rclk_q <= 1'b0;
        end else if (ev_word) begin
            rclk_q <= ~rise_sel;
        end else if (bit_done_q && bit_cnt_q == deser_pkg::STROBE_BIT) begin
            rclk_q <= rise_sel;
        end
    end

    assign data_out   = data_q;
    assign rclk_out   = rclk_q;
    assign data_oe    = awake & oe_en & locked;
    assign rclk_oe    = awake & oe_en & locked;
    assign lock_n_out = ~locked;
    assign lock_n_oe  = awake;

    ////////////////////////////////////////////////////////////////////////
    // AHB-Lite slave: zero wait states, always OKAY.

    logic       addr_ph;
    logic       wr_pend_q;
    logic [7:0] wr_addr_q;
    logic [31:0] rd_d;
    logic [31:0] rdata_q;
    logic       wr_ctrl;
    logic       wr_irq;
    logic       wr_mask;
    logic       wr_loss;

    assign addr_ph   = hsel & htrans[1] & hready;
    assign hreadyout = 1'b1;
    assign hresp     = 1'b0;
    assign hrdata    = rdata_q;

    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            wr_pend_q <= 1'b0;
            wr_addr_q <= '0;
        end else if (hready) begin
            wr_pend_q <= addr_ph & hwrite;
            wr_addr_q <= haddr[7:0];
        end
    end

    assign wr_ctrl = wr_pend_q && wr_addr_q == deser_pkg::ADDR_CTRL;
    assign wr_irq  = wr_pend_q && wr_addr_q == deser_pkg::ADDR_IRQ_STATUS;
    assign wr_mask = wr_pend_q && wr_addr_q == deser_pkg::ADDR_IRQ_MASK;
    assign wr_loss = wr_pend_q && wr_addr_q == deser_pkg::ADDR_LOSS_COUNT;

    // The relock bit is a one-cycle command; it never reads back as one.
    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            random_en_q <= deser_pkg::CTRL_RANDOM_EN_RESET;
            relock_q    <= 1'b0;
        end else begin
            relock_q <= wr_ctrl & hwdata[deser_pkg::CTRL_RELOCK];
            if (wr_ctrl) begin
                random_en_q <= hwdata[deser_pkg::CTRL_RANDOM_EN];
            end
        end
    end

    ////////////////////////////////////////////////////////////////////////
    // Interrupts and loss counter.

    logic [2:0] irq_st_q;
    logic [2:0] irq_mask_q;
    logic [2:0] irq_ev;
    logic [2:0] irq_clr;
    logic [7:0] loss_cnt_q;

    always_comb begin
        irq_ev = '0;
        irq_ev[deser_pkg::IRQ_ACQUIRED] = ev_acq;
        irq_ev[deser_pkg::IRQ_LOST]     = ev_lost;
        irq_ev[deser_pkg::IRQ_WORD]     = ev_word;
    end

    assign irq_clr = wr_irq ? hwdata[2:0] : 3'h0;

    // A new event in the clearing cycle keeps its bit set.
    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            irq_st_q <= '0;
        end else begin
            irq_st_q <= (irq_st_q & ~irq_clr) | irq_ev;
        end
    end

    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            irq_mask_q <= deser_pkg::IRQ_MASK_RESET;
        end else if (wr_mask) begin
            irq_mask_q <= hwdata[2:0];
        end
    end

    assign irq = |(irq_st_q & irq_mask_q);

    // Saturates; a write clears it, and a loss in that cycle counts one.
    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            loss_cnt_q <= '0;
        end else if (wr_loss) begin
            loss_cnt_q <= {7'h00, ev_lost};
        end else if (ev_lost && loss_cnt_q != 8'hff) begin
            loss_cnt_q <= loss_cnt_q + 8'h01;
        end
    end

    ////////////////////////////////////////////////////////////////////////
    // Read data, taken in the address phase.

    always_comb begin
        rd_d = '0;
        unique case (haddr[7:0])
            deser_pkg::ADDR_CTRL: begin
                rd_d[deser_pkg::CTRL_RANDOM_EN] = random_en_q;
            end
            deser_pkg::ADDR_STATUS: begin
                rd_d[deser_pkg::ST_LOCKED] = locked;
                rd_d[deser_pkg::ST_AWAKE]  = awake;
                rd_d[deser_pkg::ST_OE]     = oe_en;
                rd_d[deser_pkg::ST_EDGE]   = rise_sel;
                rd_d[deser_pkg::ST_ACTIVE] = active_q;
                rd_d[deser_pkg::ST_FSM_LO +: 2] = st_q;
                rd_d[deser_pkg::ST_BAD_LO +: 3] = bad_q;
            end
            deser_pkg::ADDR_DATA: begin
                rd_d[9:0] = data_q;
            end
            deser_pkg::ADDR_IRQ_STATUS: begin
                rd_d[2:0] = irq_st_q;
            end
            deser_pkg::ADDR_IRQ_MASK: begin
                rd_d[2:0] = irq_mask_q;
            end
            deser_pkg::ADDR_LOSS_COUNT: begin
                rd_d[7:0] = loss_cnt_q;
            end
            default: begin
                rd_d = '0;
            end
        endcase
    end

    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            rdata_q <= '0;
        end else if (addr_ph && !hwrite) begin
            rdata_q <= rd_d;
        end
    end

endmodule // deserializer_lock_output_ctrl

//--- common/deser_pkg.sv
package deser_pkg;

    localparam int         DATA_BITS         = 10;
    localparam int         WORD_BITS         = 12;
    localparam logic [3:0] LAST_BIT          = 4'hb;
    localparam logic [3:0] STROBE_BIT        = 4'h6;
    localparam logic [2:0] LOSS_LIMIT        = 3'h4;
    localparam logic [4:0] RANDOM_LOCK_WORDS = 5'h10;
    localparam logic [4:0] SYNC_LOCK_WORDS   = 5'h02;
    // Five ones then five zeros leave the start bit as the only rising step in the frame,
    // so a stream of sync words can only be framed one way.
    localparam logic [9:0] SYNC_WORD         = 10'h01f;

    localparam int CLK_PERIOD_NS = 100;
    localparam int IDLE_TIME_NS  = 6400;
    // A longest time: rounds down.
    localparam int IDLE_CYCLES   = IDLE_TIME_NS / CLK_PERIOD_NS;

    localparam logic [7:0] ADDR_CTRL       = 8'h00;
    localparam logic [7:0] ADDR_STATUS     = 8'h04;
    localparam logic [7:0] ADDR_DATA       = 8'h08;
    localparam logic [7:0] ADDR_IRQ_STATUS = 8'h0c;
    localparam logic [7:0] ADDR_IRQ_MASK   = 8'h10;
    localparam logic [7:0] ADDR_LOSS_COUNT = 8'h14;

    localparam int CTRL_RANDOM_EN = 0;
    localparam int CTRL_RELOCK    = 1;
    localparam logic CTRL_RANDOM_EN_RESET = 1'b1;

    localparam int ST_LOCKED = 0;
    localparam int ST_AWAKE  = 1;
    localparam int ST_OE     = 2;
    localparam int ST_EDGE   = 3;
    localparam int ST_ACTIVE = 4;
    localparam int ST_FSM_LO = 8;
    localparam int ST_BAD_LO = 12;

    localparam int IRQ_W        = 3;
    localparam int IRQ_ACQUIRED = 0;
    localparam int IRQ_LOST     = 1;
    localparam int IRQ_WORD     = 2;
    localparam logic [2:0] IRQ_MASK_RESET = 3'h0;

    typedef enum logic [1:0] {
        LK_SEARCH  = 2'b00,
        LK_CONFIRM = 2'b01,
        LK_LOCKED  = 2'b11
    } lock_state_t;

endpackage

//--- hdl/sync_two.sv
`timescale 1ns/100ps

module sync_two #(
    parameter int WIDTH = 1
) (
    input  wire logic             clk,
    input  wire logic             rst_n,
    input  wire logic [WIDTH-1:0] d,
    output logic      [WIDTH-1:0] q
);

    logic [WIDTH-1:0] meta_q;

    // The first stage feeds the second stage and nothing else.
    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            meta_q <= '0;
            q      <= '0;
        end else begin
            meta_q <= d;
            q      <= meta_q;
        end
    end

endmodule // sync_two

//--- tb/deser_ctrl_asserts.sv
`timescale 1ns/100ps

module deser_ctrl_asserts (
    input wire logic       hclk,
    input wire logic       hresetn,
    input wire logic       link_clock,
    input wire logic       sleep_n,
    input wire logic       out_enable,
    input wire logic       strobe_rising,
    input wire logic [9:0] data_out,
    input wire logic       data_oe,
    input wire logic       rclk_out,
    input wire logic       rclk_oe,
    input wire logic       lock_n_out,
    input wire logic       lock_n_oe
);
    logic       link_q;
    logic [6:0] idle_q;

    // Counts from the raw link edge, so the bound below allows for the synchroniser.
    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            link_q <= 1'b0;
            idle_q <= 7'h00;
        end else begin
            link_q <= link_clock;
            if (link_q != link_clock) idle_q <= 7'h00;
            else if (idle_q != 7'h7f) idle_q <= idle_q + 7'h01;
        end
    end

    ////////////////////////////////////////////////////////////
    default clocking @(posedge hclk); endclocking
    default disable iff (!hresetn);

    sequence s_on;
        (sleep_n && out_enable)[*3];
    endsequence
    sequence s_off;
        (sleep_n && !out_enable)[*3];
    endsequence

    property p_float_unlocked;
        lock_n_out |-> !data_oe && !rclk_oe;
    endproperty
    property p_drive;
        s_on ##0 !lock_n_out |-> data_oe && rclk_oe && lock_n_oe;
    endproperty
    property p_disabled;
        s_off |-> !data_oe && !rclk_oe && lock_n_oe;
    endproperty
    property p_sleep;
        (!sleep_n)[*4] |-> !lock_n_oe && !data_oe && !rclk_oe && lock_n_out;
    endproperty
    property p_rclk_idle;
        lock_n_out ##1 lock_n_out |-> !rclk_out;
    endproperty
    property p_strobe;
        $changed(data_out) && !lock_n_out && strobe_rising == $past(strobe_rising, 4)
            |-> rclk_out == !strobe_rising;
    endproperty
    property p_word_hold;
        $changed(data_out) && !lock_n_out |=> ($stable(data_out) || lock_n_out)[*8];
    endproperty
    property p_idle_loss;
        idle_q == 7'h48 |-> lock_n_out;
    endproperty

    a_float_unlocked: assert property (p_float_unlocked) else $error("driven while unlocked");
    a_drive: assert property (p_drive) else $error("outputs not driven while locked");
    a_disabled: assert property (p_disabled) else $error("disable not honoured");
    a_sleep: assert property (p_sleep) else $error("sleep not honoured");
    a_rclk_idle: assert property (p_rclk_idle) else $error("clock runs while unlocked");
    a_strobe: assert property (p_strobe) else $error("data moved on strobe edge");
    a_word_hold: assert property (p_word_hold) else $error("data changed mid word");
    a_idle_loss: assert property (p_idle_loss) else $error("no loss on dead link");
endmodule // deser_ctrl_asserts

bind deserializer_lock_output_ctrl deser_ctrl_asserts deser_ctrl_asserts_inst (.hclk, .hresetn,
    .link_clock, .sleep_n, .out_enable, .strobe_rising, .data_out, .data_oe, .rclk_out,
    .rclk_oe, .lock_n_out, .lock_n_oe);

//--- tb/serializer_model.sv
`timescale 1ns/100ps

module serializer_model (
    input  wire logic       run,
    input  wire logic       sync_request_a,
    input  wire logic       sync_request_b,
    input  wire logic       corrupt,
    input  wire logic [9:0] payload,
    output logic            link_clock,
    output logic            serial_in_pos,
    output logic            serial_in_neg,
    output logic            word_toggle
);
    logic [11:0] word;
    logic        bad;

    initial begin
        link_clock = 1'b0;
        serial_in_pos = 1'b0;
        serial_in_neg = 1'b0;
        word_toggle = 1'b0;
        #37;
        forever begin
            if (!run) begin
                // A dead, changing level, so a stale bit can never look valid.
                serial_in_pos = ~serial_in_pos;
                serial_in_neg = serial_in_pos;
                #800;
            end else begin
                word = {1'b0, (sync_request_a || sync_request_b) ? deser_pkg::SYNC_WORD : payload,
                        1'b1};
                bad = corrupt;
                word_toggle = ~word_toggle;
                for (int i = 0; i < deser_pkg::WORD_BITS; i++) begin
                    serial_in_pos = word[i];
                    serial_in_neg = (bad && (i == 0 || i == 11)) ? word[i] : ~word[i];
                    #400 link_clock = 1'b1;
                    #400 link_clock = 1'b0;
                end
            end
        end
    end
endmodule // serializer_model

//--- tb/deserializer_lock_output_ctrl_tb.sv
`timescale 1ns/100ps

`define CHK(a, e) begin comparisons++; if ((a) !== (e)) begin bad_count++; $display("BAD t=%0t got=%h exp=%h", $time, (a), (e)); end end

module deserializer_lock_output_ctrl_tb;
    logic        hclk = 1'b0;
    logic        hresetn = 1'b0;
    logic        hsel = 1'b0;
    logic        hwrite = 1'b0;
    logic [1:0]  htrans = 2'h0;
    logic [2:0]  hsize = 3'h2;
    logic [31:0] haddr = 32'h0;
    logic [31:0] hwdata = 32'h0;
    logic [31:0] hrdata;
    logic [31:0] rd;
    logic        hreadyout;
    logic        hresp;
    logic        irq;
    logic        link_clock;
    logic        serial_in_pos;
    logic        serial_in_neg;
    logic        word_toggle;
    logic        sleep_n = 1'b1;
    logic        out_enable = 1'b1;
    logic        strobe_rising = 1'b1;
    logic [9:0]  data_out;
    logic        data_oe;
    logic        rclk_out;
    logic        rclk_oe;
    logic        lock_n_out;
    logic        lock_n_oe;
    logic        run = 1'b0;
    logic        sync_fb = 1'b1;
    logic        sync_request_b = 1'b0;
    logic        corrupt = 1'b0;
    logic [9:0]  payload = 10'h007;
    int          bad_count = 0;
    int          comparisons = 0;
    int          cycles = 0;
    // A floating lock pin reads as a request, as a pull-up on the board would make it.
    wire         lock_pin = lock_n_oe ? lock_n_out : 1'bz;
    wire         sync_request_a = sync_fb && (lock_pin !== 1'b0);

    always #50 hclk = ~hclk;

    deserializer_lock_output_ctrl deserializer_lock_output_ctrl_inst (.hclk, .hresetn, .hsel,
        .haddr, .htrans, .hwrite, .hsize, .hwdata, .hready(hreadyout), .hreadyout, .hresp,
        .hrdata, .irq, .link_clock, .serial_in_pos, .serial_in_neg, .sleep_n, .out_enable,
        .strobe_rising, .data_out, .data_oe, .rclk_out, .rclk_oe, .lock_n_out, .lock_n_oe);

    serializer_model serializer_model_inst (.run, .sync_request_a, .sync_request_b, .corrupt,
        .payload, .link_clock, .serial_in_pos, .serial_in_neg, .word_toggle);

    ////////////////////////////////////////////////////////////
    task automatic bus(input logic wr, input logic [7:0] a, input logic [31:0] wd);
        @(posedge hclk);
        hsel <= 1'b1;
        haddr <= {24'h0, a};
        hwrite <= wr;
        htrans <= 2'h2;
        do @(posedge hclk); while (hreadyout !== 1'b1);
        htrans <= 2'h0;
        hsel <= 1'b0;
        hwdata <= wd;
        do @(posedge hclk); while (hreadyout !== 1'b1);
        rd = hrdata;
    endtask

    task automatic wait_lock(input logic v, input int maxc);
        for (int i = 0; i < maxc && lock_n_out !== v; i++) @(negedge hclk);
    endtask

    task automatic finish_test();
        if (bad_count == 0 && comparisons > 0) $display("Testbench passed");
        else $display("Testbench failed");
        $finish;
    endtask

    always @(posedge hclk) begin
        cycles++;
        if (cycles == 30000) begin
            bad_count++;
            finish_test();
        end
    end

    ////////////////////////////////////////////////////////////
    task automatic t_idle();
        repeat (200) @(negedge hclk);
        `CHK(lock_n_out, 1'b1)
        `CHK(data_oe, 1'b0)
        `CHK({hresp, hreadyout}, 2'b01)
        bus(1'b0, 8'h00, 32'h0);
        `CHK(rd, 32'h1)
        bus(1'b0, 8'h10, 32'h0);
        `CHK(rd, 32'h0)
        bus(1'b1, 8'h20, 32'hffff_ffff);
        bus(1'b0, 8'h20, 32'h0);
        `CHK(rd, 32'h0)
    endtask

    task automatic t_sync();
        bus(1'b1, 8'h10, 32'h1);
        @(posedge hclk);
        run <= 1'b1;
        wait_lock(1'b0, 3000);
        `CHK(lock_n_out, 1'b0)
        `CHK(data_oe, 1'b1)
        `CHK(irq, 1'b1)
        repeat (3) @(word_toggle);
        @(negedge hclk);
        `CHK(data_out, 10'h007)
        bus(1'b0, 8'h04, 32'h0);
        `CHK(rd, 32'h0000_031f)
        bus(1'b0, 8'h08, 32'h0);
        `CHK(rd, 32'h0000_0007)
        bus(1'b1, 8'h0c, 32'h1);
        @(negedge hclk);
        `CHK(irq, 1'b0)
    endtask

    task automatic t_loss();
        sync_fb <= 1'b0;
        bus(1'b1, 8'h10, 32'h2);
        @(word_toggle);
        @(posedge hclk);
        corrupt <= 1'b1;
        repeat (4) @(word_toggle);
        @(negedge hclk);
        `CHK(lock_n_out, 1'b0)
        @(word_toggle);
        @(negedge hclk);
        `CHK(lock_n_out, 1'b1)
        `CHK(irq, 1'b1)
        @(posedge hclk);
        corrupt <= 1'b0;
        sync_request_b <= 1'b1;
        bus(1'b0, 8'h14, 32'h0);
        `CHK(rd, 32'h1)
        bus(1'b1, 8'h0c, 32'h2);
        @(negedge hclk);
        `CHK(irq, 1'b0)
        wait_lock(1'b0, 3000);
        `CHK(lock_n_out, 1'b0)
        @(posedge hclk);
        sync_request_b <= 1'b0;
    endtask

    task automatic t_random();
        // Random lock off and a forced search: with no sync there is nothing to lock to.
        bus(1'b1, 8'h00, 32'h2);
        repeat (2500) @(negedge hclk);
        `CHK(lock_n_out, 1'b1)
        bus(1'b1, 8'h00, 32'h3);
        bus(1'b0, 8'h00, 32'h0);
        `CHK(rd, 32'h1)
        wait_lock(1'b0, 3000);
        `CHK(lock_n_out, 1'b0)
    endtask

    task automatic t_enable();
        @(posedge hclk);
        out_enable <= 1'b0;
        repeat (4) @(negedge hclk);
        `CHK({data_oe, rclk_oe, lock_n_oe, lock_n_out}, 4'b0010)
        @(posedge hclk);
        out_enable <= 1'b1;
        strobe_rising <= 1'b0;
        payload <= 10'h00f;
        repeat (3) @(word_toggle);
        @(negedge hclk);
        `CHK(data_out, 10'h00f)
        @(posedge hclk);
        strobe_rising <= 1'b1;
    endtask

    task automatic t_sleep();
        @(posedge hclk);
        sleep_n <= 1'b0;
        sync_fb <= 1'b1;
        repeat (5) @(negedge hclk);
        `CHK({lock_n_oe, data_oe, rclk_oe}, 3'b000)
        @(posedge hclk);
        sleep_n <= 1'b1;
        wait_lock(1'b0, 3000);
        `CHK(lock_n_out, 1'b0)
        // A silent link must drop lock and float the data outputs, then relock once it returns.
        @(posedge hclk);
        run <= 1'b0;
        repeat (250) @(negedge hclk);
        `CHK({lock_n_out, data_oe}, 2'b10)
        @(posedge hclk);
        run <= 1'b1;
        wait_lock(1'b0, 3000);
        `CHK(lock_n_out, 1'b0)
    endtask

    initial begin
        repeat (4) @(posedge hclk);
        hresetn <= 1'b1;
        t_idle();
        t_sync();
        t_loss();
        t_random();
        t_enable();
        t_sleep();
        finish_test();
    end
endmodule // deserializer_lock_output_ctrl_tb
